// [design/irq_mode_pkg.sv]
// Constants and types for the interrupt mode and routing slice
package irq_mode_pkg;
	// ==========================================
	// Sources and field layout
	localparam int NSRC = 4;
	localparam int NCHAN = 8;
	localparam int LANE_W = 8;
	localparam int LVL_LSB = 0;
	localparam int LVL_W = 3;
	localparam int ROUTE_BIT = 4;
	localparam int COND_LSB = 5;
	localparam int COND_W = 2;
	// ==========================================
	// Active-condition and level codes
	localparam logic [1:0] COND_LOW = 2'h0;
	localparam logic [1:0] COND_HIGH = 2'h1;
	localparam logic [1:0] COND_FALL = 2'h2;
	localparam logic [1:0] COND_RISE = 2'h3;
	localparam logic [2:0] LVL_DISABLED = 3'h0;
	// ==========================================
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] MODE_CTRL_B_OFF = 8'h08;
	localparam logic [7:0] PIN_STATUS_OFF = 8'h0c;
	localparam logic [31:0] MODE_CTRL_B_RESET = 32'h0000_0000;
	localparam logic [31:0] MODE_CTRL_B_WMASK = 32'h7777_7777;
	// ==========================================
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	// ==========================================
	// Whole state of the top module
	typedef struct packed {
		logic [NSRC-1:0] pin_meta;
		logic [NSRC-1:0] pin_sync;
		logic [NSRC-1:0] pin_prev;
		logic [31:0] mode_ctrl;
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		logic [31:0] rdata;
		logic readyout;
		logic resp;
		logic [NSRC-1:0] irq_req;
		logic [NSRC*LVL_W-1:0] irq_level;
		logic [NCHAN-1:0] dma_trig;
	} state_t;
endpackage

// [design/src_cond_detect.sv]
// Active-condition detector for one interrupt source
`timescale 1ns/1ps
module src_cond_detect
	import irq_mode_pkg::*;
(
	input wire logic [1:0] cond,
	input wire logic level_now,
	input wire logic level_prev,
	output logic hit
);
	// ==========================================
	// Condition decode
	always_comb begin
		unique case (cond)
			COND_LOW: hit = ~level_now;
			COND_HIGH: hit = level_now;
			COND_FALL: hit = level_prev & ~level_now;
			COND_RISE: hit = ~level_prev & level_now;
		endcase
	end
endmodule

// [design/irq_mode_slice.sv]
// Mode, routing and level control for interrupt sources 8 to 11
`timescale 1ns/1ps
module irq_mode_slice
	import irq_mode_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [NSRC-1:0] EXT_REQ_PIN,
	output logic [NSRC-1:0] IRQ_REQ,
	output logic [NSRC*LVL_W-1:0] IRQ_LEVEL,
	output logic [NCHAN-1:0] DMA_TRIG
);
	state_t s_q;
	state_t s_d;
	logic [NSRC-1:0] hit;

	// ==========================================
	// Field extraction
	function automatic logic [7:0] lane(input logic [31:0] r, input int i);
		lane = r[i*LANE_W +: LANE_W];
	endfunction

	function automatic logic [1:0] lane_cond(input logic [31:0] r, input int i);
		logic [7:0] l;
		l = lane(r, i);
		lane_cond = l[COND_LSB +: COND_W];
	endfunction

	function automatic logic lane_route(input logic [31:0] r, input int i);
		logic [7:0] l;
		l = lane(r, i);
		lane_route = l[ROUTE_BIT];
	endfunction

	function automatic logic [2:0] lane_lvl(input logic [31:0] r, input int i);
		logic [7:0] l;
		l = lane(r, i);
		lane_lvl = l[LVL_LSB +: LVL_W];
	endfunction

	// ==========================================
	// Per-source detectors, one pin each
	generate
		for (genvar g = 0; g < NSRC; g++) begin : g_src
			src_cond_detect u_det (
				.cond(lane_cond(s_q.mode_ctrl, g)),
				.level_now(s_q.pin_sync[g]),
				.level_prev(s_q.pin_prev[g]),
				.hit(hit[g])
			);
		end
	endgenerate

	// ==========================================
	// Next state
	always_comb begin
		logic addr_ok;
		logic [31:0] wmerged;
		logic [2:0] lvl;
		addr_ok = 1'b0;
		wmerged = '0;
		lvl = '0;
		s_d = s_q;
		// Pin synchronisers
		s_d.pin_meta = EXT_REQ_PIN;
		s_d.pin_sync = s_q.pin_meta;
		s_d.pin_prev = s_q.pin_sync;
		// Data phase of a write
		if (s_q.wr_pend && s_q.wr_addr == MODE_CTRL_B_OFF) begin
			wmerged = HWDATA & MODE_CTRL_B_WMASK;
			s_d.mode_ctrl = wmerged;
		end
		s_d.wr_pend = 1'b0;
		s_d.readyout = 1'b1;
		s_d.resp = HRESP_OKAY;
		// Address phase
		addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
		if (addr_ok) begin
			if (HWRITE) begin
				s_d.wr_pend = 1'b1;
				s_d.wr_addr = HADDR[ADDR_W-1:0];
				s_d.rdata = '0;
			end else begin
				unique case (HADDR[ADDR_W-1:0])
					MODE_CTRL_B_OFF: s_d.rdata = s_d.mode_ctrl;
					PIN_STATUS_OFF: s_d.rdata = {{(32-2*NSRC){1'b0}}, s_q.irq_req | hit, s_q.pin_sync};
					default: s_d.rdata = '0;
				endcase
			end
		end
		// Request routing from the current settings
		s_d.dma_trig = '0;
		for (int i = 0; i < NSRC; i++) begin
			lvl = lane_lvl(s_q.mode_ctrl, i);
			if (lane_route(s_q.mode_ctrl, i)) begin
				s_d.irq_req[i] = 1'b0;
				s_d.irq_level[i*LVL_W +: LVL_W] = LVL_DISABLED;
				s_d.dma_trig[lvl] = s_d.dma_trig[lvl] | hit[i];
			end else begin
				s_d.irq_req[i] = hit[i] && (lvl != LVL_DISABLED);
				s_d.irq_level[i*LVL_W +: LVL_W] = lvl;
			end
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '{mode_ctrl: MODE_CTRL_B_RESET, readyout: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign HRDATA = s_q.rdata;
	assign HREADYOUT = s_q.readyout;
	assign HRESP = s_q.resp;
	assign IRQ_REQ = s_q.irq_req;
	assign IRQ_LEVEL = s_q.irq_level;
	assign DMA_TRIG = s_q.dma_trig;
endmodule

// [tb/irq_sink.sv]
// Sink model of the DMA controller, collecting every trigger seen
`timescale 1ns/1ps
module irq_sink (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] trig,
	output logic [7:0] seen
);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) seen <= 8'h00;
		else seen <= seen | trig;
	end
endmodule

// [tb/irq_mode_slice_monitor.sv]
// Port assertions of the mode slice
`timescale 1ns/1ps
module irq_mode_slice_monitor import irq_mode_pkg::*; (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic [3:0] EXT_REQ_PIN,
	input wire logic [3:0] IRQ_REQ,
	input wire logic [11:0] IRQ_LEVEL,
	input wire logic [7:0] DMA_TRIG
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	wire logic [3:0] on = {|IRQ_LEVEL[11:9], |IRQ_LEVEL[8:6], |IRQ_LEVEL[5:3], |IRQ_LEVEL[2:0]};
	wire logic q = HTRANS != HTRANS_NONSEQ;
	AST_RST_CLR: assert property ($rose(NRST) |-> !IRQ_REQ && !IRQ_LEVEL && !DMA_TRIG)
		else $error("not reset");
	AST_RSV_ZERO: assert property ((HSEL && HREADYOUT && HTRANS == HTRANS_NONSEQ && !HWRITE
		&& HADDR[ADDR_W-1:0] == MODE_CTRL_B_OFF) |=> (HRDATA & ~MODE_CTRL_B_WMASK) == 32'h0)
		else $error("bit 3 or 7 set");
	AST_LVL0_OFF: assert property ((IRQ_REQ & ~on) == 4'h0)
		else $error("request at level 0");
	AST_QUIET: assert property ((q && $stable(EXT_REQ_PIN))[*5] |-> $stable(IRQ_REQ) && $stable(DMA_TRIG))
		else $error("output moved");
	AST_OWN_PIN: assert property ((q && $stable(EXT_REQ_PIN[0]))[*5] |-> $stable(IRQ_REQ[0]))
		else $error("source 8 moved");
endmodule
bind irq_mode_slice irq_mode_slice_monitor i_mon (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .EXT_REQ_PIN(EXT_REQ_PIN),
	.IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL), .DMA_TRIG(DMA_TRIG));

// [tb/tb_irq_mode_slice.sv]
// Bench for the mode and routing slice
`timescale 1ns/1ps
module tb_irq_mode_slice import irq_mode_pkg::*;;
	logic SYS_CLK = 0, NRST = 0, HWRITE = 0, HREADYOUT, HRESP;
	logic [1:0] HTRANS = 2'h0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
	logic [3:0] EXT_REQ_PIN = 4'h0, IRQ_REQ;
	logic [11:0] IRQ_LEVEL;
	logic [7:0] DMA_TRIG, seen, sm = 8'h00;
	int fail_count = 0, n_tests = 0, k;
	always #2 SYS_CLK = ~SYS_CLK;
	irq_mode_slice i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_REQ_PIN(EXT_REQ_PIN), .IRQ_REQ(IRQ_REQ),
		.IRQ_LEVEL(IRQ_LEVEL), .DMA_TRIG(DMA_TRIG));
	irq_sink i_sink (.clk(SYS_CLK), .nrst(NRST), .trig(DMA_TRIG), .seen(seen));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	task automatic wait_ready();
		k = 0;
		do tick(1); while (HREADYOUT !== 1'b1 && ++k < 20);
		if (k > 19) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		HTRANS <= HTRANS_NONSEQ;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		wait_ready();
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_ready();
		q = HRDATA;
		chk("resp", HRESP, HRESP_OKAY);
	endtask
	initial begin
		tick(12);
		NRST <= 1'b1;
		tick(1);
		bus(1'b0, 8'h08, 32'h0);
		chk("reset", q, MODE_CTRL_B_RESET);
		bus(1'b1, 8'h08, 32'hffff_ffff);
		bus(1'b0, 8'h08, 32'h0);
		chk("mask", q, MODE_CTRL_B_WMASK);
		bus(1'b0, 8'h10, 32'h0);
		chk("unmapped", q, 32'h0);
		for (int c = 0; c < 4; c++) begin
			EXT_REQ_PIN <= {3'h0, !c[0]};
			bus(1'b1, 8'h08, {25'h0, c[1:0], 2'h0, 3'(c + 1)});
			tick(6);
			chk("idle", IRQ_REQ, 0);
			EXT_REQ_PIN <= {3'h0, c[0]};
			k = 0;
			do tick(1); while (IRQ_REQ[0] !== 1'b1 && ++k < 9);
			if (k > 8) begin
				fail_count++;
				end_of_test();
			end
			chk("level", IRQ_LEVEL, 12'(c + 1));
			tick(1);
			chk("hold", IRQ_REQ, {3'h0, !c[1]});
		end
		bus(1'b1, 8'h08, 32'h20);
		tick(6);
		chk("off", IRQ_REQ, 0);
		for (int n = 0; n < 8; n++) begin
			EXT_REQ_PIN <= 4'h0;
			bus(1'b1, 8'h08, 32'(8'h30 + n) << (8 * (n % 4)));
			EXT_REQ_PIN <= 4'h1 << (n % 4);
			tick(6);
			chk("dma", DMA_TRIG, 8'h1 << n);
			chk("irq", {IRQ_REQ, IRQ_LEVEL}, 0);
			sm = sm | (8'h1 << n);
			chk("sink", seen, sm);
			if (n == 3) begin
				bus(1'b0, 8'h0c, 32'h0);
				chk("status", q, 32'h0000_00f8);
			end
		end
		// Reset in mid-run with a source routed and active
		NRST <= 1'b0;
		tick(2);
		chk("reset trig", DMA_TRIG, 8'h00);
		NRST <= 1'b1;
		tick(1);
		bus(1'b0, 8'h08, 32'h0);
		chk("rereset", q, MODE_CTRL_B_RESET);
		chk("reset outs", {IRQ_REQ, IRQ_LEVEL, DMA_TRIG}, 32'h0);
		end_of_test();
	end
endmodule
